// File: rtl/ebs_strobe.sv
`include "ebs_defs.svh"
`default_nettype none
module ebs_strobe
	import ebs_pkg::*;
(
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [11:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// External bus pins
	input  wire logic        bus_width_select_input,
	input  wire logic [15:0] muxed_in,
	output logic      [15:0] muxed_out,
	output logic      [15:0] muxed_oe,
	output logic             shared_strobe_pin,
	output logic             upper_byte_pin,
	output logic             rd_n,
	output logic             wr_n
);
	import ebs_pkg::*;

	ebs_state_t             state_q;
	logic [31:0]            cfg_q;
	logic [17:0]            req_q;
	logic [15:0]            xdata_q;
	logic [15:0]            rdata_q;
	logic                   start_q;
	logic [`EBS_CNT_W-1:0]  cnt_q;
	logic                   ph_q;
	logic [11:0]            ph_addr_q;
	logic                   ph_write_q;
	logic                   wide_bus;
	logic                   upper_lane;
	logic                   lower_lane;
	logic                   ale_q;
	logic                   adv_n_q;
	logic                   port5_bit_zero;
	ebs_pin_mode_t          pin_mode;

	wire logic byte_pin_function_select = cfg_q[`EBS_CFG_FUNC_BIT];
	wire logic wide_bus_allow_bit       = cfg_q[`EBS_CFG_WIDE_BIT];
	wire logic narrow_bus_allow_bit     = cfg_q[`EBS_CFG_NARROW_BIT];
	wire logic lowest_address_bit       = req_q[`EBS_REQ_ADDR_LSB];
	// A taken request that has not started yet already counts as busy
	wire logic busy                     = start_q || state_q != EBS_IDLE;
	wire logic take = hsel && hready && htrans[1];

	assign pin_mode       = ebs_pin_mode_t'(cfg_q[`EBS_CFG_MODE_LSB +: 2]);
	assign port5_bit_zero = cfg_q[`EBS_CFG_PORT_BIT];
	assign hreadyout      = 1'b1;
	assign hresp          = 1'b0;

	always_comb begin
		if (wide_bus_allow_bit && narrow_bus_allow_bit)
			wide_bus = bus_width_select_input;
		else
			wide_bus = wide_bus_allow_bit;
	end

	ebs_byte_sel u_sel (
		.wide_bus           (wide_bus),
		.word_access        (req_q[`EBS_REQ_SIZE_BIT]),
		.lowest_address_bit (lowest_address_bit),
		.upper_lane         (upper_lane),
		.lower_lane         (lower_lane)
	);

	// Address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_q       <= 1'b0;
			ph_addr_q  <= 12'h000;
			ph_write_q <= 1'b0;
		end else if (hready) begin
			ph_q       <= take;
			ph_addr_q  <= haddr;
			ph_write_q <= hwrite;
		end
	end

	wire logic wr_en = ph_q && ph_write_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			cfg_q <= `EBS_CFG_RESET;
		else if (wr_en && ph_addr_q == `EBS_OFF_CFG)
			cfg_q <= hwdata;
	end

	// Requests while busy are dropped, status shows busy
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req_q   <= 18'h00000;
			start_q <= 1'b0;
		end else begin
			start_q <= 1'b0;
			if (wr_en && ph_addr_q == `EBS_OFF_REQ && !busy) begin
				req_q   <= hwdata[17:0];
				start_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			xdata_q <= 16'h0000;
		else if (wr_en && ph_addr_q == `EBS_OFF_XDATA)
			xdata_q <= hwdata[15:0];
	end

	// Cycle sequencer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= EBS_IDLE;
			cnt_q   <= '0;
		end else begin
			unique case (state_q)
			EBS_IDLE: begin
				if (start_q) begin
					state_q <= EBS_ADDR;
					cnt_q   <= '0;
				end
			end
			EBS_ADDR: begin
				if (cnt_q == `EBS_CNT_W'(`EBS_ALE_CYC - 1)) begin
					state_q <= EBS_DATA;
					cnt_q   <= '0;
				end else begin
					cnt_q <= cnt_q + 1'b1;
				end
			end
			EBS_DATA: begin
				if (cnt_q == `EBS_CNT_W'(`EBS_DATA_CYC - 1))
					state_q <= EBS_DONE;
				else
					cnt_q <= cnt_q + 1'b1;
			end
			EBS_DONE:
				state_q <= EBS_IDLE;
			endcase
		end
	end

	// Read data captured on the last data cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			rdata_q <= 16'h0000;
		else if (state_q == EBS_DATA && !req_q[`EBS_REQ_WRITE_BIT] &&
			cnt_q == `EBS_CNT_W'(`EBS_DATA_CYC - 1))
			rdata_q <= muxed_in;
	end

	// strobe pulse in the address phase only
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			ale_q <= 1'b0;
		else
			ale_q <= (state_q == EBS_IDLE && start_q) ||
				(state_q == EBS_ADDR &&
				cnt_q != `EBS_CNT_W'(`EBS_ALE_CYC - 1));
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			adv_n_q <= 1'b1;
		else
			adv_n_q <= !((state_q == EBS_IDLE && start_q) ||
				state_q == EBS_ADDR || state_q == EBS_DATA &&
				cnt_q != `EBS_CNT_W'(`EBS_DATA_CYC - 1));
	end

	always_comb begin
		unique case (pin_mode)
		EBS_PIN_ALE:  shared_strobe_pin = ale_q;
		EBS_PIN_ADV:  shared_strobe_pin = adv_n_q;
		default:      shared_strobe_pin = port5_bit_zero;
		endcase
	end

	// address stands on the lines while the latch strobe is high
	always_comb begin
		muxed_out = xdata_q;
		muxed_oe  = 16'h0000;
		if (state_q == EBS_ADDR) begin
			muxed_out = req_q[15:0];
			muxed_oe  = 16'hffff;
		end else if (state_q == EBS_DATA && req_q[`EBS_REQ_WRITE_BIT]) begin
			muxed_oe  = 16'hffff;
		end
	end

	wire logic in_data = state_q == EBS_DATA;
	wire logic wr_cyc  = in_data && req_q[`EBS_REQ_WRITE_BIT];

	assign rd_n = !(in_data && !req_q[`EBS_REQ_WRITE_BIT]);
	assign wr_n = !(wr_cyc && lower_lane);

	always_comb begin
		if (byte_pin_function_select)
			upper_byte_pin = !(!adv_n_q && wide_bus && upper_lane);
		else
			upper_byte_pin = !(wr_cyc && upper_lane);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (take && !hwrite) begin
			unique case (haddr)
			`EBS_OFF_CFG:    hrdata <= cfg_q;
			`EBS_OFF_REQ:    hrdata <= {14'h0000, req_q};
			`EBS_OFF_STATUS: hrdata <= {31'h0000_0000, busy};
			`EBS_OFF_XDATA:  hrdata <= {16'h0000, xdata_q};
			`EBS_OFF_RDATA:  hrdata <= {16'h0000, rdata_q};
			default:         hrdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule
`default_nettype wire

// File: rtl/ebs_defs.svh
`ifndef EBS_DEFS_SVH
`define EBS_DEFS_SVH
// Register byte offsets on the AHB-Lite slave
`define EBS_OFF_CFG      12'h000
`define EBS_OFF_REQ      12'h004
`define EBS_OFF_STATUS   12'h008
`define EBS_OFF_XDATA    12'h00c
`define EBS_OFF_RDATA    12'h010
// Configuration word fields
`define EBS_CFG_PORT_BIT   0
`define EBS_CFG_WIDE_BIT   1
`define EBS_CFG_FUNC_BIT   2
`define EBS_CFG_NARROW_BIT 3
`define EBS_CFG_MODE_LSB   4
`define EBS_CFG_RESET      32'h0000_0016
// Request word fields
`define EBS_REQ_ADDR_LSB   0
`define EBS_REQ_WRITE_BIT  16
`define EBS_REQ_SIZE_BIT   17
// Phase lengths in hclk cycles, and the phase counter width in bits
`define EBS_ALE_CYC        2
`define EBS_DATA_CYC       4
`define EBS_CNT_W          3
`endif

// File: rtl/ebs_pkg.sv
`default_nettype none
package ebs_pkg;
	typedef enum logic [1:0] {
		EBS_PIN_PORT = 2'h0,
		EBS_PIN_ALE  = 2'h1,
		EBS_PIN_ADV  = 2'h2
	} ebs_pin_mode_t;
	typedef enum logic [3:0] {
		EBS_IDLE = 4'h1,
		EBS_ADDR = 4'h2,
		EBS_DATA = 4'h4,
		EBS_DONE = 4'h8
	} ebs_state_t;
endpackage
`default_nettype wire

// File: rtl/ebs_byte_sel.sv
`default_nettype none
module ebs_byte_sel (
	// Transfer description
	input  wire logic wide_bus,
	input  wire logic word_access,
	input  wire logic lowest_address_bit,
	// Lane results
	output logic      upper_lane,
	output logic      lower_lane
);
	always_comb begin
		if (!wide_bus) begin
			upper_lane = 1'b0;
			lower_lane = 1'b1;
		end else if (word_access) begin
			upper_lane = 1'b1;
			lower_lane = 1'b1;
		end else begin
			upper_lane = lowest_address_bit;
			lower_lane = !lowest_address_bit;
		end
	end
endmodule
`default_nettype wire

// File: tb/ebs_strobe_asserts.sv
`default_nettype none
module ebs_strobe_chk (
	// Watched pins
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [15:0] muxed_oe,
	input wire logic        shared_strobe_pin,
	input wire logic        upper_byte_pin,
	input wire logic        rd_n,
	input wire logic        wr_n
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_addr;
		$rose(shared_strobe_pin) && muxed_oe == 16'hffff;
	endsequence
	sequence s_data;
		!shared_strobe_pin && (!rd_n || !wr_n || !upper_byte_pin);
	endsequence
	a_ale_pulse: assert property (s_addr |=> shared_strobe_pin ##1 s_data)
		else $error("address strobe pulse wrong");
	a_adv_span: assert property ($fell(shared_strobe_pin) &&
		$past(muxed_oe) == 16'h0 && muxed_oe == 16'hffff
		|-> !shared_strobe_pin[*6] ##1 shared_strobe_pin)
		else $error("address valid span wrong");
	a_rd_len: assert property ($fell(rd_n) |-> !rd_n[*4] ##1 rd_n)
		else $error("read strobe length wrong");
	a_wr_len: assert property ($fell(wr_n) |-> !wr_n[*4] ##1 wr_n)
		else $error("write strobe length wrong");
	a_upper_valid: assert property (!upper_byte_pin |->
		!rd_n || muxed_oe != 16'h0) else $error("upper pin outside cycle");
	a_upper_span: assert property ($fell(upper_byte_pin) |->
		!upper_byte_pin[*4]) else $error("upper pin too short");
	a_rw_excl: assert property (rd_n || wr_n)
		else $error("read and write together");
	a_no_wait: assert property (hreadyout && !hresp)
		else $error("bus slave not ready");
endmodule
bind ebs_strobe ebs_strobe_chk u_chk (.hclk, .hresetn, .hreadyout,
	.hresp, .muxed_oe, .shared_strobe_pin, .upper_byte_pin, .rd_n, .wr_n);
`default_nettype wire

// File: tb/ebs_ext_mem.sv
`default_nettype none
module ebs_ext_mem (
	// Pins seen by the memory
	input  wire logic        hclk,
	input  wire logic        ale,
	input  wire logic [15:0] oe,
	input  wire logic [15:0] ad,
	input  wire logic        rd_n,
	output logic      [15:0] rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] lat_q;
	logic [15:0] last_q = 16'h0;
	always @(posedge hclk) begin
		if (ale && oe == 16'hffff)
			lat_q <= ad;
		last_q <= rdata;
	end
	// both lanes; released bus shows inverse of last value
	assign rdata = !rd_n ? lat_q ^ 16'h5a3c : ~last_q;
endmodule
`default_nettype wire

// File: tb/testbench.sv
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic        hclk = 0, hresetn = 0, hwrite = 0, bw = 0;
	logic [1:0]  htrans = 2'h0;
	logic [11:0] haddr = 12'h0;
	logic [31:0] hwdata = 32'h0, hrdata, r, seed = 32'h0000_c34f;
	logic [15:0] muxed_in, muxed_out, muxed_oe;
	logic        hreadyout, hresp, shared_strobe_pin, upper_byte_pin;
	logic        rd_n, wr_n;
	int          num_errors = 0, check_count = 0;
	logic [7:0]  cfgs [7] = '{8'h16, 8'h12, 8'h1c, 8'h1e, 8'h26, 8'h07, 8'h00};
	ebs_strobe u_ebs_strobe (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans,
		.hwrite, .hsize(3'h2), .hready(hreadyout), .hwdata, .hrdata,
		.hreadyout, .hresp, .bus_width_select_input(bw), .muxed_in,
		.muxed_out, .muxed_oe, .shared_strobe_pin, .upper_byte_pin, .rd_n,
		.wr_n);
	ebs_ext_mem u_ebs_ext_mem (.hclk, .ale(shared_strobe_pin),
		.oe(muxed_oe), .ad(muxed_out), .rd_n, .rdata(muxed_in));
	always #4 hclk = ~hclk;
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	// Strobe-high, read, write and upper-low cycle counts in a 10-cycle window
	function automatic logic [19:0] exp_cnt(input logic [7:0] c,
		input logic [17:0] q, input logic b);
		logic wd, up;
		logic [4:0] s, u;
		wd = (c[1] & c[3]) ? b : c[1];
		up = wd & (q[17] | q[0]);
		s = c[5] ? 5'h4 : c[4] ? 5'h2 : {5{c[0]}} & 5'ha;
		u = c[2] ? (up ? 5'h6 : 5'h0) : (up & q[16] ? 5'h4 : 5'h0);
		return {s, q[16] ? 5'h0 : 5'h4,
			(q[16] & (~wd | q[17] | ~q[0])) ? 5'h4 : 5'h0, u};
	endfunction
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= a;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask
	task automatic op(input logic [7:0] c, input logic [17:0] q,
		input logic [15:0] x);
		logic [4:0] s = 0, rl = 0, wl = 0, ul = 0;
		logic [15:0] wv = 0;
		xfer(1, 12'h00c, {16'h0, x});
		xfer(1, 12'h004, {14'h0, q});
		repeat (10) begin
			@(posedge hclk);
			#1;
			s += shared_strobe_pin;
			rl += !rd_n;
			wl += !wr_n;
			ul += !upper_byte_pin;
			// Last driven word: address on reads, write data on writes
			if (muxed_oe == 16'hffff)
				wv = muxed_out;
		end
		@(posedge hclk);
		cmp({12'h0, s, rl, wl, ul}, {12'h0, exp_cnt(c, q, bw)});
		cmp({16'h0, wv}, {16'h0, q[16] ? x : q[15:0]});
		if (c[5:4] == 2'h1 && q[17:16] == 2'h2 && c[1] && (!c[3] || bw)) begin
			xfer(0, 12'h010, 32'h0);
			cmp({16'h0, r[15:0]}, {16'h0, q[15:0] ^ 16'h5a3c});
		end
		xfer(0, 12'h008, 32'h0);
		cmp({31'h0, r[0]}, 32'h0);
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#50000;
		num_errors++;
		report_and_stop;
	end
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1;
		@(posedge hclk);
		xfer(0, 12'h000, 32'h0);
		cmp(r, 32'h16);
		xfer(0, 12'h020, 32'h0);
		cmp(r, 32'h0);
		// Corner: busy shows at once and a second request is dropped
		xfer(1, 12'h004, {14'h0, 18'h0_0020});
		xfer(0, 12'h008, 32'h0);
		cmp({31'h0, r[0]}, 32'h1);
		xfer(1, 12'h004, {14'h0, 18'h1_0040});
		repeat (10) @(posedge hclk);
		xfer(0, 12'h004, 32'h0);
		cmp(r, 32'h20);
		foreach (cfgs[i]) begin
			xfer(1, 12'h000, {24'h0, cfgs[i]});
			op(cfgs[i], 18'h1_0001, 16'ha55a);
			op(cfgs[i], 18'h2_0100, 16'h0ff0);
			repeat (4) begin
				seed = xs(seed);
				bw <= seed[20];
				op(cfgs[i], {seed[17:1], seed[0] & ~seed[17]},
					seed[31:16]);
			end
			$display("test cfg %h done", cfgs[i]);
		end
		report_and_stop;
	end
endmodule
`default_nettype wire
